// ### dv/item_store_model.sv
// item storage model behind the engine's read port
// answers the cycle after rd_en; scrambled at every other time
`timescale 1ns/1ns
`default_nettype none
module item_store_model (
    input wire ref_clk,
    input wire rd_en,
    input wire [1:0] rd_space,
    input wire [15:0] rd_addr,
    output logic rd_bit,
    output logic [15:0] rd_word
);
    always @(posedge ref_clk) begin
        if (rd_en) begin
            rd_bit <= rd_addr[0] ^ rd_addr[3] ^ rd_space[0];
            rd_word <= {rd_addr[7:0] ^ 8'h5a, rd_addr[7:0]};
        end else begin
            // stale data must not look valid
            rd_bit <= ~rd_bit;
            rd_word <= ~rd_word;
        end
    end
endmodule // item_store_model
`default_nettype wire

// ### dv/modbus_tcp_server_pdu_engine_tb.sv
// self-checking bench for the modbus server pdu engine
// bench plays the client on the falling edge; item data from a model
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
$display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module modbus_tcp_server_pdu_engine_tb;
    logic ref_clk = 0, rst_b = 0, port_cfg_valid = 0, req_valid = 0;
    logic req_last = 0, rsp_ready = 0, req_ready, rsp_valid, rsp_last;
    logic rd_en, rd_bit, fwd_valid;
    logic [1:0] rd_space;
    logic [7:0] req_data = 0, rsp_data;
    logic [15:0] port_cfg = 0, service_port, rd_addr, rd_word;
    logic [7:0] exp_q[$];
    logic [31:0] seed = 45029;
    int fails = 0, checked = 0, cyc = 0;
    logic [39:0] tbl[15] = '{40'h0100000001, 40'h010003000d, 40'h0200050010,
        40'h0300020003, 40'h030000007d, 40'h01000007d0, 40'h0100000000,
        40'h02000007d1, 40'h030000007e, 40'h0107ff0002, 40'h0300ff0002,
        40'h0500000001, 40'h0400000001, 40'h0600000001, 40'h1000000001};
    modbus_tcp_server_pdu_engine modbus_tcp_server_pdu_engine_i (.*);
    item_store_model item_store_model_i (.*);
    initial forever #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 50000) begin
            fails++;
            final_report();
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic void model(int fc, a, q);
        int sp = fc == 3 ? 256 : 2048;
        int n = fc == 3 ? 125 : 2000;
        logic [7:0] e = 8'(fc) | 8'h80;
        if (fc < 1 || fc > 3) exp_q = {e, 8'h01};
        else if (q < 1 || q > n) exp_q = {e, 8'h03};
        else if (a + q > sp) exp_q = {e, 8'h02};
        else begin
            exp_q = {8'(fc), 8'(fc == 3 ? 2 * q : (q + 7) / 8)};
            for (int i = 0; i < q; i++) begin
                if (fc == 3) begin
                    exp_q.push_back(8'(a + i) ^ 8'h5a);
                    exp_q.push_back(8'(a + i));
                end else begin
                    if (i % 8 == 0) exp_q.push_back(8'h00);
                    exp_q[$][i % 8] = 1'((a + i) ^ ((a + i) >> 3) ^ (fc - 1));
                end
            end
        end
    endfunction
    task automatic run(logic [39:0] t);
        int fc = t[39:32];
        int w = 0;
        logic [7:0] pdu[5] = '{t[39:32], t[31:24], t[23:16], t[15:8], t[7:0]};
        model(fc, t[31:16], t[15:0]);
        for (int i = 0; i < 5; i++) begin
            @(negedge ref_clk);
            {req_valid, req_data, req_last} = {1'b1, pdu[i], i == 4};
            while (!req_ready) @(negedge ref_clk);
        end
        @(negedge ref_clk);
        req_valid = 0;
        req_last = 0;
        if (fc inside {4, 6, 16}) begin
            while (!fwd_valid && w < 9) begin
                @(negedge ref_clk);
                w++;
            end
            `CHK(fwd_valid, 1'b1)
        end else while (exp_q.size() > 0) begin
            @(negedge ref_clk);
            rsp_ready = rnd() % 3 != 0;
            if (rsp_valid && rsp_ready) begin
                `CHK(rsp_data, exp_q[0])
                `CHK(rsp_last, 1'(exp_q.size() == 1))
                void'(exp_q.pop_front());
            end
        end
        @(negedge ref_clk);
        rsp_ready = 0;
    endtask
    task automatic final_report();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge ref_clk);
        rst_b = 1;
        `CHK(service_port, 16'h01f6)
        @(negedge ref_clk);
        port_cfg = rnd();
        port_cfg_valid = 1;
        @(negedge ref_clk);
        port_cfg_valid = 0;
        `CHK(service_port, port_cfg)
        foreach (tbl[i]) run(tbl[i]);
        repeat (8) run({8'(rnd() % 3 + 1), 16'(rnd() % 200), 16'(rnd() % 120 + 1)});
        final_report();
    end
endmodule // modbus_tcp_server_pdu_engine_tb
`default_nettype wire

// ### dv/pdu_engine_checker_asserts.sv
// port assertions for the pdu engine
// one clock, async active-low reset; bound onto the engine
`timescale 1ns/1ns
`default_nettype none
module pdu_engine_checker (
    input wire ref_clk,
    input wire rst_b,
    input wire port_cfg_valid,
    input wire [15:0] port_cfg,
    input wire [15:0] service_port,
    input wire req_valid,
    input wire [7:0] req_data,
    input wire req_last,
    input wire req_ready,
    input wire rsp_valid,
    input wire [7:0] rsp_data,
    input wire rsp_last,
    input wire rsp_ready,
    input wire fwd_valid
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    reg [7:0] fc;
    reg first;
    reg rfirst;
    wire acc = req_valid && req_ready;
    wire take = rsp_valid && rsp_ready;
    wire fwd = fc == 8'h04 || fc == 8'h06 || fc == 8'h10;
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            first <= 1'b1;
            rfirst <= 1'b0;
            fc <= 8'h00;
        end else begin
            if (acc) first <= req_last;
            if (acc && first) fc <= req_data;
            rfirst <= (acc && req_last) || (rfirst && !take);
        end
    end
    chk_port_reset: assert property (
        $rose(rst_b) |-> service_port == 16'h01f6) else $error("port reset");
    chk_port_load: assert property (
        port_cfg_valid |=> service_port == $past(port_cfg)) else $error("port");
    chk_busy_last: assert property (
        acc && req_last |=> !req_ready) else $error("ready after last");
    chk_echo_code: assert property (
        acc && req_last && !fwd |-> ##[1:3] rsp_valid &&
        (rsp_data == fc || rsp_data == (fc | 8'h80)))
        else $error("first byte");
    chk_fwd_pulse: assert property (
        acc && req_last && fwd |-> ##[1:3] fwd_valid) else $error("fwd");
    chk_rsp_hold: assert property (
        rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
        else $error("hold");
    chk_err_code: assert property (
        rfirst && take && rsp_data == (fc | 8'h80) |=> ##[0:3] rsp_valid &&
        rsp_last && rsp_data inside {8'h01, 8'h02, 8'h03}) else $error("exc");
    chk_unsup_code: assert property (
        rfirst && take && !fwd && !(fc inside {8'h01, 8'h02, 8'h03})
        |=> ##[0:3] rsp_valid && rsp_data == 8'h01) else $error("exc 01");
    cover property (fwd_valid);
    cover property (take && rsp_data == 8'h83);
    cover property (rsp_valid && !rsp_ready);
endmodule // pdu_engine_checker
bind modbus_tcp_server_pdu_engine pdu_engine_checker pdu_engine_checker_i (.*);
`default_nettype wire

// ### hw/modbus_tcp_server_pdu_engine.v
// request pdu parser and response builder for a modbus tcp server
// assumes the tcp stack delivers one pdu byte per cycle with a last flag,
// and that coil, input and holding data answer a read one cycle later
`include "pdu_engine_defines.vh"
`timescale 1ns/1ns
`default_nettype none

// Contract
// - service port defaults to 502, configurable
// - server supports codes 01,02,03,04,06,10; engine answers 01-03 only, 04,06,10 just pulse fwd_valid
// - first request byte selects the operation
// - response byte 0 echoes function code
// - error frame byte 0 is code plus 0x80
// - error frame byte 1 is exception code
// - address from bytes 1 high, 2 low
// - quantity from bytes 3 high, 4 low
// - read coils quantity 1 to 2000
// - coils fetched from start for quantity
// - bit reads: byte count, eight bits per byte
// - coil bit 0 is first addressed output
// - unused final bits padded with zero
// - discrete inputs quantity 1 to 2000
// - input bit 0 is first addressed input
// - holding registers quantity 1 to 125
// - holding byte count is twice registers
// - register words sent high byte first
// - bit 0 is least significant bit
// - bad address in span gives exception 02
// - quantity out of range gives exception 03
module modbus_tcp_server_pdu_engine (
    input wire ref_clk,
    input wire rst_b,
    input wire port_cfg_valid,
    input wire [15:0] port_cfg,
    output reg [15:0] service_port,
    input wire req_valid,
    input wire [7:0] req_data,
    input wire req_last,
    output wire req_ready,
    output reg rsp_valid,
    output reg [7:0] rsp_data,
    output reg rsp_last,
    input wire rsp_ready,
    output reg rd_en,
    output reg [1:0] rd_space,
    output reg [15:0] rd_addr,
    input wire rd_bit,
    input wire [15:0] rd_word,
    output reg fwd_valid
);

localparam [2:0] S_RECV = 3'h0;
localparam [2:0] S_CHECK = 3'h1;
localparam [2:0] S_HDR = 3'h2;
localparam [2:0] S_FETCH = 3'h3;
localparam [2:0] S_WAIT = 3'h4;
localparam [2:0] S_SEND = 3'h5;
localparam [2:0] S_SKIP = 3'h6;
localparam [2:0] S_GRAB = 3'h7;

localparam [1:0] SP_COIL = 2'h0;
localparam [1:0] SP_INPUT = 2'h1;
localparam [1:0] SP_HOLD = 2'h2;

reg [2:0] state;
reg [2:0] hdr_cnt;
reg [7:0] func;
reg [15:0] start_addr;
reg [15:0] quantity;
reg [15:0] item;
reg [2:0] bit_pos;
reg [7:0] pack;
reg hi_sent;
reg [7:0] lo_hold;
reg [1:0] phase;
reg [7:0] exc;
// read data only stands one cycle; held here across sink stalls
reg bit_hold;
reg [15:0] word_hold;

wire is_bit = (func == `FC_READ_COILS) || (func == `FC_READ_INPUTS);
wire is_hold = (func == `FC_READ_HOLDING);
wire [16:0] span_end = {1'b0, start_addr} + {1'b0, quantity};
wire [15:0] qty_max = is_bit ? `BIT_QTY_MAX : `REG_QTY_MAX;
wire [15:0] space_size = is_bit ? `BIT_SPACE : `REG_SPACE;
wire [15:0] bytes_bit = (quantity + 16'h0007) >> 3;
wire [15:0] bytes_reg = {quantity[14:0], 1'b0};
wire last_item = (item + 16'h0001 == quantity);

assign req_ready = (state == S_RECV) || (state == S_SKIP);

// configured port overrides the default only when supplied
always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        service_port <= `SERVICE_PORT_DEFAULT;
    end else if (port_cfg_valid) begin
        service_port <= port_cfg;
    end
end

always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        state <= S_RECV;
        hdr_cnt <= 3'h0;
        func <= 8'h00;
        start_addr <= 16'h0000;
        quantity <= 16'h0000;
        item <= 16'h0000;
        bit_pos <= 3'h0;
        pack <= 8'h00;
        hi_sent <= 1'b0;
        lo_hold <= 8'h00;
        phase <= 2'h0;
        exc <= 8'h00;
        bit_hold <= 1'b0;
        word_hold <= 16'h0000;
        rsp_valid <= 1'b0;
        rsp_data <= 8'h00;
        rsp_last <= 1'b0;
        rd_en <= 1'b0;
        rd_space <= SP_COIL;
        rd_addr <= 16'h0000;
        fwd_valid <= 1'b0;
    end else begin
        rd_en <= 1'b0;
        fwd_valid <= 1'b0;
        if (rsp_valid && rsp_ready) begin
            rsp_valid <= 1'b0;
            rsp_last <= 1'b0;
        end
        case (state)
        S_RECV: begin
            if (req_valid) begin
                case (hdr_cnt)
                3'h0: func <= req_data;
                3'h1: start_addr[15:8] <= req_data;
                3'h2: start_addr[7:0] <= req_data;
                3'h3: quantity[15:8] <= req_data;
                3'h4: quantity[7:0] <= req_data;
                default: ;
                endcase
                if (hdr_cnt != `REQ_HDR_LEN) begin
                    hdr_cnt <= hdr_cnt + 3'h1;
                end
                if (req_last) begin
                    hdr_cnt <= 3'h0;
                    state <= S_CHECK;
                end
            end
        end
        S_CHECK: begin
            // all checks before any read leaves the engine
            exc <= 8'h00;
            state <= S_HDR;
            phase <= 2'h0;
            if (func == `FC_READ_INPUT_REGS || func == `FC_WRITE_SINGLE_REG
                    || func == `FC_WRITE_MULTI_REGS) begin
                // handled by the neighbouring word engine
                fwd_valid <= 1'b1;
                state <= S_RECV;
            end else if (!is_bit && !is_hold) begin
                exc <= `EXC_ILLEGAL_FUNCTION;
            end else if (quantity < `QTY_MIN || quantity > qty_max) begin
                exc <= `EXC_ILLEGAL_VALUE;
            end else if (span_end > {1'b0, space_size}) begin
                exc <= `EXC_ILLEGAL_ADDRESS;
            end
        end
        S_HDR: begin
            if (!rsp_valid || rsp_ready) begin
                rsp_valid <= 1'b1;
                phase <= phase + 2'h1;
                if (exc != 8'h00) begin
                    if (phase == 2'h0) begin
                        rsp_data <= func | `ERR_FLAG;
                    end else begin
                        rsp_data <= exc;
                        rsp_last <= 1'b1;
                        state <= S_RECV;
                    end
                end else if (phase == 2'h0) begin
                    rsp_data <= func;
                end else begin
                    // byte count fits eight bits for legal quantities
                    rsp_data <= is_bit ? bytes_bit[7:0]
                                       : bytes_reg[7:0];
                    item <= 16'h0000;
                    bit_pos <= 3'h0;
                    pack <= 8'h00;
                    hi_sent <= 1'b0;
                    state <= S_FETCH;
                end
            end
        end
        S_FETCH: begin
            rd_en <= 1'b1;
            rd_space <= (func == `FC_READ_COILS) ? SP_COIL
                      : is_bit ? SP_INPUT : SP_HOLD;
            rd_addr <= start_addr + item;
            state <= S_WAIT;
        end
        S_WAIT: begin
            state <= S_GRAB;
        end
        S_GRAB: begin
            bit_hold <= rd_bit;
            word_hold <= rd_word;
            state <= S_SEND;
        end
        S_SEND: begin
            if (is_bit) begin
                // lsb first: first addressed item lands in bit 0
                if (bit_pos == 3'h7 || last_item) begin
                    if (!rsp_valid || rsp_ready) begin
                        rsp_valid <= 1'b1;
                        // zero pad comes from pack cleared per byte
                        rsp_data <= pack | ({7'h00, bit_hold} << bit_pos);
                        rsp_last <= last_item;
                        pack <= 8'h00;
                        bit_pos <= 3'h0;
                        item <= item + 16'h0001;
                        state <= last_item ? S_RECV : S_FETCH;
                    end
                end else begin
                    pack <= pack | ({7'h00, bit_hold} << bit_pos);
                    bit_pos <= bit_pos + 3'h1;
                    item <= item + 16'h0001;
                    state <= S_FETCH;
                end
            end else if (!rsp_valid || rsp_ready) begin
                rsp_valid <= 1'b1;
                if (!hi_sent) begin
                    rsp_data <= word_hold[15:8];
                    lo_hold <= word_hold[7:0];
                    hi_sent <= 1'b1;
                end else begin
                    rsp_data <= lo_hold;
                    rsp_last <= last_item;
                    hi_sent <= 1'b0;
                    item <= item + 16'h0001;
                    state <= last_item ? S_RECV : S_FETCH;
                end
            end
        end
        S_SKIP: begin
            state <= S_RECV;
        end
        default: state <= S_RECV;
        endcase
    end
end

endmodule // modbus_tcp_server_pdu_engine
`default_nettype wire

// ### shared/pdu_engine_defines.vh
// constants for the modbus server pdu engine
// included by the engine; definitions only
`ifndef PDU_ENGINE_DEFINES_VH
`define PDU_ENGINE_DEFINES_VH
`define SERVICE_PORT_DEFAULT 16'h01f6
`define FC_READ_COILS 8'h01
`define FC_READ_INPUTS 8'h02
`define FC_READ_HOLDING 8'h03
`define FC_READ_INPUT_REGS 8'h04
`define FC_WRITE_SINGLE_REG 8'h06
`define FC_WRITE_MULTI_REGS 8'h10
`define ERR_FLAG 8'h80
`define EXC_ILLEGAL_FUNCTION 8'h01
`define EXC_ILLEGAL_ADDRESS 8'h02
`define EXC_ILLEGAL_VALUE 8'h03
`define BIT_QTY_MAX 16'h07d0
`define REG_QTY_MAX 16'h007d
`define QTY_MIN 16'h0001
`define REQ_HDR_LEN 3'h5
`define BITS_PER_BYTE 4'h8
`define BIT_SPACE 16'h0800
`define REG_SPACE 16'h0100
`endif
